// *** verilog/cpbp_packer.sv ***
// Purpose: Serialises interpolated YUV pixels into a byte stream for the host buffer.
// Assumes: Pixel source and byte sink run on REF_CLK; pixels arrive in raster order.
// Notes: One pixel per two cycles at most; simplicity was preferred over full throughput.
// Function
// (RQ1) YUYV pair goes out as Y even, U even, Y odd, V even.
// (RQ2) Luma for every pixel; chroma only from the even pixel of each pair.
// (RQ3) YUYV luma is unsigned 8-bit, code equals level.
// (RQ4) Chroma is 8-bit offset binary, 0x80 is zero.
// (RQ5) Monochrome uses the same YUV luma, sending only Y.
// (RQ6) Monochrome sends exactly one luma byte per pixel, in order.
// (RQ7) Monochrome luma is unsigned 8-bit, code equals level.
// (RQ8) Each frame starts at row 0, column 0, upper-left corner.
// (RQ9) Pixels run in raster order, ending at the bottom-right pixel.
// (RQ10) An odd pixel count is an error for YUYV frames.
`timescale 1ns/1ps
`include "cpbp_cfg.svh"

module cpbp_packer (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Frame setup, sampled on FRAME_START while idle.
  input wire logic FRAME_START,
  input wire logic FRAME_MODE,
  input wire logic [`CPBP_DIM_W-1:0] FRAME_COLS,
  input wire logic [`CPBP_DIM_W-1:0] FRAME_ROWS,
  // Pixel input stream.
  input wire logic PIX_VALID,
  output logic PIX_READY,
  input wire logic [`CPBP_DW-1:0] PIX_Y,
  input wire logic [`CPBP_DW-1:0] PIX_U,
  input wire logic [`CPBP_DW-1:0] PIX_V,
  // Byte output stream.
  output logic BYTE_VALID,
  input wire logic BYTE_READY,
  output logic [`CPBP_DW-1:0] BYTE_DATA,
  output logic BYTE_SOF,
  output logic BYTE_EOF,
  // Status.
  output logic FRAME_BUSY,
  output logic FRAME_ERR
);

  // ----------------------------------------------------------------------
  // Reset release.
  // ----------------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n_q;

  // Assert at once, release after two edges so every flop leaves reset together.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // Handshake terms.
  // ----------------------------------------------------------------------
  cpbp_pkg::cpbp_state_t st_q;
  cpbp_pkg::cpbp_mode_t mode_q;
  logic [`CPBP_DIM_W-1:0] cols_q;
  logic [`CPBP_DIM_W-1:0] rows_q;
  logic [`CPBP_DIM_W-1:0] col_q;
  logic [`CPBP_DIM_W-1:0] row_q;
  logic rdy_q;
  logic ov_q;
  logic last_q;
  logic sof_pend_q;
  logic [`CPBP_DW-1:0] u_hold;
  logic [`CPBP_DW-1:0] v_hold;
  logic take;
  logic free;
  logic emit;
  logic load;
  logic is_last;
  logic start_ok;
  logic start_bad;
  logic odd_count;
  logic want;
  logic ov_d;

  assign take = PIX_VALID && rdy_q;
  assign free = !ov_q || BYTE_READY;
  // Chroma bytes need no new pixel, only room in the output register.
  assign emit = ((st_q == cpbp_pkg::ST_UE) || (st_q == cpbp_pkg::ST_VE)) && free;
  assign load = (take && (st_q != cpbp_pkg::ST_DROP)) || emit;
  assign is_last = (col_q == (cols_q - `CPBP_DIM_ONE)) && (row_q == (rows_q - `CPBP_DIM_ONE)); // RQ9
  assign odd_count = FRAME_COLS[0] && FRAME_ROWS[0];
  assign start_bad = (FRAME_COLS == `CPBP_DIM_ZERO) || (FRAME_ROWS == `CPBP_DIM_ZERO) ||
                     ((FRAME_MODE == cpbp_pkg::MODE_YUYV) && odd_count); // RQ10
  assign start_ok = FRAME_START && (st_q == cpbp_pkg::ST_IDLE);
  assign want = (st_q == cpbp_pkg::ST_MONO) || (st_q == cpbp_pkg::ST_EVEN) ||
                (st_q == cpbp_pkg::ST_ODD) || (st_q == cpbp_pkg::ST_DROP);
  assign ov_d = load ? 1'b1 : (BYTE_READY ? 1'b0 : ov_q);

  // ----------------------------------------------------------------------
  // Frame setup.
  // ----------------------------------------------------------------------
  // Setup is latched so the source may change it mid-frame without harm.
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_q <= cpbp_pkg::MODE_MONO8;
      cols_q <= `CPBP_DIM_ZERO;
      rows_q <= `CPBP_DIM_ZERO;
    end else if (start_ok) begin
      mode_q <= cpbp_pkg::cpbp_mode_t'(FRAME_MODE);
      cols_q <= FRAME_COLS;
      rows_q <= FRAME_ROWS;
    end
  end

  // ----------------------------------------------------------------------
  // Raster position.
  // ----------------------------------------------------------------------
  // Column runs left to right, then the row steps down.
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      col_q <= `CPBP_DIM_ZERO;
      row_q <= `CPBP_DIM_ZERO;
    end else if (start_ok) begin
      col_q <= `CPBP_DIM_ZERO; // RQ8
      row_q <= `CPBP_DIM_ZERO; // RQ8
    end else if (take) begin
      if (col_q == (cols_q - `CPBP_DIM_ONE)) begin
        col_q <= `CPBP_DIM_ZERO; // RQ9
        row_q <= row_q + `CPBP_DIM_ONE; // RQ9
      end else begin
        col_q <= col_q + `CPBP_DIM_ONE; // RQ9
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer.
  // ----------------------------------------------------------------------
  // A rejected YUYV frame is still drained so the pixel source never hangs.
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= cpbp_pkg::ST_IDLE;
    end else begin
      case (st_q)
        cpbp_pkg::ST_IDLE: begin
          if (start_ok) begin
            if ((FRAME_COLS == `CPBP_DIM_ZERO) || (FRAME_ROWS == `CPBP_DIM_ZERO)) begin
              st_q <= cpbp_pkg::ST_IDLE;
            end else if (start_bad) begin
              st_q <= cpbp_pkg::ST_DROP; // RQ10
            end else if (FRAME_MODE == cpbp_pkg::MODE_YUYV) begin
              st_q <= cpbp_pkg::ST_EVEN;
            end else begin
              st_q <= cpbp_pkg::ST_MONO; // RQ5
            end
          end
        end
        cpbp_pkg::ST_MONO: begin
          if (take && is_last) begin
            st_q <= cpbp_pkg::ST_IDLE; // RQ6
          end
        end
        cpbp_pkg::ST_EVEN: begin
          if (take) begin
            st_q <= cpbp_pkg::ST_UE; // RQ1
          end
        end
        cpbp_pkg::ST_UE: begin
          if (emit) begin
            st_q <= cpbp_pkg::ST_ODD; // RQ1
          end
        end
        cpbp_pkg::ST_ODD: begin
          if (take) begin
            st_q <= cpbp_pkg::ST_VE; // RQ1
          end
        end
        cpbp_pkg::ST_VE: begin
          if (emit) begin
            st_q <= last_q ? cpbp_pkg::ST_IDLE : cpbp_pkg::ST_EVEN; // RQ1
          end
        end
        cpbp_pkg::ST_DROP: begin
          if (take && is_last) begin
            st_q <= cpbp_pkg::ST_IDLE;
          end
        end
        default: begin
          st_q <= cpbp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Remembers whether the odd pixel just taken closes the frame.
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      last_q <= 1'b0;
    end else if (take && (st_q == cpbp_pkg::ST_ODD)) begin
      last_q <= is_last;
    end
  end

  // ----------------------------------------------------------------------
  // Even pixel holding register.
  // ----------------------------------------------------------------------
  cpbp_pair_hold u_hold_even (
    .clk(REF_CLK),
    .rst_n(rst_n_q),
    .load(take && (st_q == cpbp_pkg::ST_EVEN)), // RQ2
    .u_in(PIX_U),
    .v_in(PIX_V),
    .u_code_q(u_hold),
    .v_code_q(v_hold)
  );

  // ----------------------------------------------------------------------
  // Pixel ready.
  // ----------------------------------------------------------------------
  // Except in ST_DROP, ready rises only when the output register will be empty, so a taken pixel always has a slot.
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdy_q <= 1'b0;
    end else begin
      rdy_q <= want && !take && ((st_q == cpbp_pkg::ST_DROP) || !ov_d);
    end
  end

  assign PIX_READY = rdy_q;

  // ----------------------------------------------------------------------
  // Output byte register.
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ov_q <= 1'b0;
    end else begin
      ov_q <= ov_d;
    end
  end

  // Luma leaves unchanged; chroma comes already encoded from the hold register.
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      BYTE_DATA <= `CPBP_BYTE_ZERO;
      BYTE_EOF <= 1'b0;
    end else if (load) begin
      case (st_q)
        cpbp_pkg::ST_UE: BYTE_DATA <= u_hold; // RQ1 RQ4
        cpbp_pkg::ST_VE: BYTE_DATA <= v_hold; // RQ1 RQ4
        default: BYTE_DATA <= PIX_Y; // RQ3 RQ7 RQ6
      endcase
      BYTE_EOF <= ((st_q == cpbp_pkg::ST_MONO) && is_last) || ((st_q == cpbp_pkg::ST_VE) && last_q);
    end
  end

  // The first byte of a good frame is marked; it carries row 0, column 0.
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sof_pend_q <= 1'b0;
      BYTE_SOF <= 1'b0;
    end else begin
      if (start_ok) begin
        sof_pend_q <= 1'b1; // RQ8
      end else if (load) begin
        sof_pend_q <= 1'b0;
      end
      if (load) begin
        BYTE_SOF <= sof_pend_q; // RQ8
      end
    end
  end

  assign BYTE_VALID = ov_q;

  // ----------------------------------------------------------------------
  // Status.
  // ----------------------------------------------------------------------
  // The error stands until the next frame start; busy covers the last byte's drain.
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      FRAME_ERR <= 1'b0;
      FRAME_BUSY <= 1'b0;
    end else begin
      if (start_ok) begin
        FRAME_ERR <= start_bad; // RQ10
      end
      FRAME_BUSY <= (st_q != cpbp_pkg::ST_IDLE) || start_ok || ov_d;
    end
  end

endmodule : cpbp_packer

// *** verilog/cpbp_cfg.svh ***
// Purpose: Named constants for the color pixel byte packer.
// Assumes: Included by the package and the design modules by bare name.
// Notes: Definitions only.
`ifndef CPBP_CFG_SVH
`define CPBP_CFG_SVH

// Width of every emitted byte and of each pixel component.
`define CPBP_DW 8
// Width of the column and row counters and of the frame dimensions.
`define CPBP_DIM_W 12
// Chroma zero level in offset binary; flipping the sign bit maps two's complement to it.
`define CPBP_CHROMA_OFS 8'h80
// Reset value of a data byte.
`define CPBP_BYTE_ZERO 8'h00
// Dimension constants.
`define CPBP_DIM_ZERO 12'h000
`define CPBP_DIM_ONE 12'h001

`endif

// *** verilog/cpbp_pkg.sv ***
// Purpose: Types and shared functions of the color pixel byte packer.
// Assumes: The constants header is on the include path.
// Notes: Nothing here is imported; users write cpbp_pkg::name.
`include "cpbp_cfg.svh"

package cpbp_pkg;

  // ----------------------------------------------------------------------
  // Output format and sequencer state.
  // ----------------------------------------------------------------------
  typedef enum logic {
    MODE_MONO8 = 1'b0,
    MODE_YUYV = 1'b1
  } cpbp_mode_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_MONO = 7'h02,
    ST_EVEN = 7'h04,
    ST_UE = 7'h08,
    ST_ODD = 7'h10,
    ST_VE = 7'h20,
    ST_DROP = 7'h40
  } cpbp_state_t;

  // ----------------------------------------------------------------------
  // Chroma encoding.
  // ----------------------------------------------------------------------
  // Two's complement -128..+127 becomes offset binary with 0x80 as zero.
  function automatic logic [`CPBP_DW-1:0] cpbp_chroma_code(input logic [`CPBP_DW-1:0] sval);
    cpbp_chroma_code = sval ^ `CPBP_CHROMA_OFS;
  endfunction : cpbp_chroma_code

endpackage : cpbp_pkg

// *** verilog/cpbp_pair_hold.sv ***
// Purpose: Holds the even pixel of a pair until its chroma bytes are sent.
// Assumes: Chroma inputs are two's complement; outputs are offset binary.
// Notes: Outputs come from registers loaded on the even pixel's handshake.
`timescale 1ns/1ps
`include "cpbp_cfg.svh"

module cpbp_pair_hold (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Capture strobe and even pixel components.
  input wire logic load,
  input wire logic [`CPBP_DW-1:0] u_in,
  input wire logic [`CPBP_DW-1:0] v_in,
  // Encoded chroma of the held pixel.
  output logic [`CPBP_DW-1:0] u_code_q,
  output logic [`CPBP_DW-1:0] v_code_q
);

  // Only the even pixel's chroma is kept; the odd pixel's chroma is discarded by design.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      u_code_q <= `CPBP_CHROMA_OFS;
      v_code_q <= `CPBP_CHROMA_OFS;
    end else if (load) begin
      u_code_q <= cpbp_pkg::cpbp_chroma_code(u_in); // RQ4 RQ2
      v_code_q <= cpbp_pkg::cpbp_chroma_code(v_in); // RQ4 RQ2
    end
  end

endmodule : cpbp_pair_hold

// *** verification/cpbp_packer_assertions.sv ***
// Purpose: Port checker for the pixel byte packer.
// Assumes: Bound to cpbp_packer; helper registers track the frame position.
// Notes: Starts count only while idle.
`timescale 1ns/1ps

module cpbp_packer_chk (
  // Watched ports.
  input wire logic REF_CLK, RST_N, FRAME_START, FRAME_MODE, PIX_VALID, PIX_READY,
  input wire logic [11:0] FRAME_COLS, FRAME_ROWS,
  input wire logic [7:0] PIX_Y, PIX_U, PIX_V, BYTE_DATA,
  input wire logic BYTE_VALID, BYTE_READY, BYTE_SOF, BYTE_EOF, FRAME_BUSY, FRAME_ERR
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic start_tk, bad, mode_q, par_q;
  logic [31:0] acc_q, tot_q;
  logic [7:0] u_q, v_q;
  // A start is taken only while idle; zero sizes and odd YUYV counts are refused.
  assign start_tk = FRAME_START && !FRAME_BUSY && !BYTE_VALID;
  assign bad = FRAME_COLS == 12'h000 || FRAME_ROWS == 12'h000 || (FRAME_MODE && FRAME_COLS[0] && FRAME_ROWS[0]);
  // Byte position, pair parity and the even pixel's chroma.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      {mode_q, par_q, acc_q, tot_q, u_q, v_q} <= '0;
    end else if (start_tk) begin
      mode_q <= FRAME_MODE;
      par_q <= 1'b0;
      acc_q <= 32'h0;
      tot_q <= (({20'h0, FRAME_COLS} * {20'h0, FRAME_ROWS}) << FRAME_MODE) - 32'h1;
    end else begin
      if (BYTE_VALID && BYTE_READY) acc_q <= acc_q + 32'h1;
      if (PIX_VALID && PIX_READY) par_q <= !par_q;
      if (PIX_VALID && PIX_READY && !par_q) {u_q, v_q} <= {PIX_U, PIX_V};
    end
  end
  sequence s_taken;
    PIX_VALID && PIX_READY && !FRAME_ERR;
  endsequence
  a_luma_follows: assert property (s_taken |=> BYTE_VALID && BYTE_DATA == $past(PIX_Y))
    else $error("luma byte does not follow the taken pixel");
  a_ready_gap: assert property (PIX_VALID && PIX_READY |=> !PIX_READY)
    else $error("pixel ready stayed high after a take");
  a_byte_hold: assert property (BYTE_VALID && !BYTE_READY |=> BYTE_VALID && $stable(BYTE_DATA))
    else $error("byte changed before acceptance");
  a_chroma_blue: assert property (BYTE_VALID && mode_q && acc_q[1:0] == 2'h1 |-> BYTE_DATA == (u_q ^ 8'h80))
    else $error("blue chroma byte wrong");
  a_chroma_red: assert property (BYTE_VALID && mode_q && acc_q[1:0] == 2'h3 |-> BYTE_DATA == (v_q ^ 8'h80))
    else $error("red chroma byte wrong");
  a_start_mark: assert property (BYTE_VALID |-> BYTE_SOF == (acc_q == 32'h0))
    else $error("start marker misplaced");
  a_end_mark: assert property (BYTE_VALID |-> BYTE_EOF == (acc_q == tot_q))
    else $error("end marker misplaced");
  a_bad_refused: assert property (start_tk && bad |=> FRAME_ERR)
    else $error("bad frame not flagged");
  a_good_frame: assert property (start_tk && !bad |=> !FRAME_ERR && FRAME_BUSY)
    else $error("good frame flagged or idle");
  a_err_silent: assert property (FRAME_ERR |-> !BYTE_VALID)
    else $error("byte sent in a refused frame");
endmodule : cpbp_packer_chk

bind cpbp_packer cpbp_packer_chk u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .FRAME_START(FRAME_START),
  .FRAME_MODE(FRAME_MODE), .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .FRAME_COLS(FRAME_COLS),
  .FRAME_ROWS(FRAME_ROWS), .PIX_Y(PIX_Y), .PIX_U(PIX_U), .PIX_V(PIX_V), .BYTE_DATA(BYTE_DATA),
  .BYTE_VALID(BYTE_VALID), .BYTE_READY(BYTE_READY), .BYTE_SOF(BYTE_SOF), .BYTE_EOF(BYTE_EOF),
  .FRAME_BUSY(FRAME_BUSY), .FRAME_ERR(FRAME_ERR));

// *** verification/cpbp_host_buf.sv ***
// Purpose: Host image buffer model that takes the packer's bytes.
// Assumes: Ready changes at the falling edge only.
// Notes: While slow, a rotating pattern stalls the packer.
`timescale 1ns/1ps

module cpbp_host_buf (
  // Clock, reset and stall control.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  // Byte stream.
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic sof,
  input wire logic eof,
  output logic byte_ready
);
  logic [9:0] got[$];
  logic [7:0] pat = 8'h96;
  initial byte_ready = 1'b0;
  // Stall pattern rotates so waits of several lengths occur.
  always @(negedge clk) begin
    pat = {pat[6:0], pat[7]};
    byte_ready <= !slow || pat[0];
  end
  // Each accepted byte lands in the buffer with its markers.
  always @(posedge clk) begin
    if (rst_n && byte_valid && byte_ready) got.push_back({eof, sof, byte_data});
  end
endmodule : cpbp_host_buf

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench for the pixel byte packer.
// Assumes: Inputs change at the falling edge.
// Notes: A queue model gives the expected byte stream of each frame.
`timescale 1ns/1ps

module tb_top;
  logic REF_CLK = 0, RST_N = 0, FRAME_START = 0, FRAME_MODE = 0, PIX_VALID = 0, slow = 0;
  logic [11:0] FRAME_COLS = 0, FRAME_ROWS = 0;
  logic [7:0] PIX_Y = 0, PIX_U = 0, PIX_V = 0, BYTE_DATA;
  logic PIX_READY, BYTE_VALID, BYTE_READY, BYTE_SOF, BYTE_EOF, FRAME_BUSY, FRAME_ERR;
  logic [15:0] lfsr = 16'h2609;
  int num_errors = 0, n_compared = 0;
  int exp_q[$];
  // Free-running 100 MHz clock.
  always #5 REF_CLK = ~REF_CLK;
  cpbp_packer dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .FRAME_START(FRAME_START), .FRAME_MODE(FRAME_MODE),
    .FRAME_COLS(FRAME_COLS), .FRAME_ROWS(FRAME_ROWS), .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY),
    .PIX_Y(PIX_Y), .PIX_U(PIX_U), .PIX_V(PIX_V), .BYTE_VALID(BYTE_VALID), .BYTE_READY(BYTE_READY),
    .BYTE_DATA(BYTE_DATA), .BYTE_SOF(BYTE_SOF), .BYTE_EOF(BYTE_EOF), .FRAME_BUSY(FRAME_BUSY),
    .FRAME_ERR(FRAME_ERR));
  cpbp_host_buf host (.clk(REF_CLK), .rst_n(RST_N), .slow(slow), .byte_valid(BYTE_VALID),
    .byte_data(BYTE_DATA), .sof(BYTE_SOF), .eof(BYTE_EOF), .byte_ready(BYTE_READY));

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    $display("Counts: %0d compared, %0d mismatches", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // One frame: start, feed pixels in raster order, model the bytes, compare the buffer.
  task automatic run_frame(input logic mode, input int cols, input int rows, input logic stall);
    int n, y, u, v, ye, ue, ve;
    logic err;
    n = cols * rows;
    err = n == 0 || (mode && n % 2 == 1);
    exp_q.delete();
    host.got.delete();
    @(negedge REF_CLK);
    slow = stall;
    FRAME_MODE = mode;
    FRAME_COLS = cols[11:0];
    FRAME_ROWS = rows[11:0];
    FRAME_START = 1'b1;
    @(negedge REF_CLK);
    if (n != 0) chk("busy", FRAME_BUSY, 1);
    for (int k = 0; k < n; k++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      y = (k < 2) ? 255 * k : lfsr[7:0];
      u = (k == 0) ? 128 : lfsr[15:8];
      v = (k == 0) ? 127 : lfsr[11:4];
      FRAME_START = k == 1;
      {PIX_Y, PIX_U, PIX_V} = {y[7:0], u[7:0], v[7:0]};
      PIX_VALID = 1'b1;
      while (PIX_READY !== 1'b1) @(negedge REF_CLK);
      @(negedge REF_CLK);
      if (!err && !mode) exp_q.push_back(y);
      if (!err && mode && k % 2 == 0) {ye, ue, ve} = {y, (u + 128) % 256, (v + 128) % 256};
      if (!err && mode && k % 2 == 1) exp_q = {exp_q, ye, ue, y, ve};
    end
    PIX_VALID = 1'b0;
    FRAME_START = 1'b0;
    while (FRAME_BUSY !== 1'b0) @(negedge REF_CLK);
    repeat (2) @(negedge REF_CLK);
    chk("frame_err", FRAME_ERR, err);
    chk("byte_count", host.got.size(), exp_q.size());
    for (int i = 0; i < exp_q.size() && i < host.got.size(); i++) begin
      chk("byte", host.got[i], {i == exp_q.size() - 1, i == 0, exp_q[i][7:0]});
    end
    $display("Test done: mode %0d size %0dx%0d", mode, cols, rows);
  endtask : run_frame

  // Main sequence: mono, YUYV, stalls, refused frames, recovery.
  initial begin
    repeat (20) @(negedge REF_CLK);
    RST_N = 1'b1;
    repeat (5) @(negedge REF_CLK);
    run_frame(1'b0, 3, 2, 1'b0);
    run_frame(1'b0, 3, 3, 1'b1);
    run_frame(1'b1, 4, 2, 1'b0);
    run_frame(1'b1, 3, 2, 1'b1);
    run_frame(1'b1, 3, 3, 1'b0);
    run_frame(1'b1, 0, 4, 1'b0);
    run_frame(1'b1, 2, 1, 1'b1);
    run_frame(1'b1, 8, 6, 1'b1);
    final_report();
  end

  // Watchdog well beyond the length of all frames.
  initial begin
    repeat (20000) @(posedge REF_CLK);
    num_errors++;
    $display("Watchdog expired");
    final_report();
  end
endmodule : tb_top
